//--- rtl/fmt_gated_accum.sv
// Purpose: Verification-mode strap, gated volume accumulation, pulse emission
// Assumes: Measuring engine answers each meas_start with one flow_vol_valid
// Notes:   flow_vol is signed, pulse units with FRAC_W fraction bits
//
// Behaviour
// - Gate low at power-up enters verification mode after one second
// - Verification mode runs measuring routines four times as often
// - Verification mode is left only by reset
// - Gate low runs a test; volume accumulates only meanwhile
// - Test volume is presented for serial readout
// - Accumulator uses the same interval results as pulse computation
// - First and last intervals are scaled by their in-test fractions
// - Final value is presented two seconds after gate release
// - Pulses stop at once when the gate is released
// - Pulse count is scheduled per one-second interval
// - Each pulse lasts 2.5 ms, between two and five
// - Output is invalid for sixteen seconds after power-up
// - No pulses for flow below cut-off or negative
// - Pulse count saturates at 128 per second
// - Pulses go out in bursts with 30 ms gaps
`timescale 1ns/1ns
`default_nettype none
module fmt_gated_accum
   import fmt_pkg::*;
#(
   parameter int unsigned ENTRY_N   = 32'(ENTRY_CYC),
   parameter int unsigned SEC_N     = 32'(SEC_CYC),
   parameter int unsigned SETTLE_N  = 32'(SETTLE_CYC),
   parameter int unsigned STARTUP_N = 32'(STARTUP_CYC),
   parameter int unsigned PULSE_N   = 32'(PULSE_CYC),
   parameter int unsigned GAP_N     = 32'(GAP_CYC),
   parameter int unsigned MEAS_N    = 32'(MEAS_CYC),
   parameter logic signed [VOL_W-1:0] MIN_CUTOFF = 24'h000001
)
(
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // Gate / strap pin, low when grounded
   input  wire logic                    gate_pin_n,
   // Measuring engine
   output logic                         meas_start,
   input  wire logic                    flow_vol_valid,
   input  wire logic signed [VOL_W-1:0] flow_vol,
   // Status
   output logic                         verif_mode,
   output logic                         out_valid,
   output logic                         test_running,
   // Serial readout data
   output logic             [ACC_W-1:0] test_vol,
   output logic                         test_vol_valid,
   // Pulse output
   output logic                         pulse_out
);

   localparam int unsigned NUM_W = VOL_W + TIM_W;

   logic              gate_m_r, gate_s_r;
   logic [31:0]       boot_r;
   logic              strap_r, verif_r, valid_r;
   logic [TIM_W-1:0]  meas_cnt_r, period, since_r, tb1_r, t_last;
   logic              meas_r;
   fmt_state_e        st_r;
   logic [ACC_W-1:0]  acc_r;
   logic [31:0]       settle_r;
   logic              rdy_r, inhib_r;
   logic [VOL_W-1:0]  last_mag_r, cur_mag;
   logic              last_neg_r;
   logic              go_r, neg_r, dv_done;
   logic [NUM_W-1:0]  num_r, dv_quo;
   logic [TIM_W-1:0]  den_r;
   logic [31:0]       sec_r, ptmr_r;
   logic signed [31:0] sacc_r, sacc_in;
   logic [7:0]        pend_r, cnt_nxt;
   fmt_phase_e        ph_r;
   logic [3:0]        burst_r;
   logic              pulse_r, pen;

   // ==========================================================
   // Pin synchroniser
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         gate_m_r <= 1'b1;
         gate_s_r <= 1'b1;
      end
      else
      begin
         gate_m_r <= gate_pin_n;
         gate_s_r <= gate_m_r;
      end
   end

   // ==========================================================
   // Power-up timing and mode entry
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         boot_r  <= '0;
         strap_r <= 1'b0;
         verif_r <= 1'b0;
         valid_r <= 1'b0;
      end
      else
      begin
         if (boot_r != STARTUP_N)
            boot_r <= boot_r + 32'h1;
         if (boot_r == STRAP_AT_CYC)
            strap_r <= !gate_s_r;
         if (boot_r == ENTRY_N && strap_r)
            verif_r <= 1'b1;
         if (boot_r == STARTUP_N)
            valid_r <= 1'b1;
      end
   end

   // ==========================================================
   // Measuring interval ticks
   // Quarter period in verification mode
   assign period = verif_r ? TIM_W'(MEAS_N / TEST_SPEEDUP) : TIM_W'(MEAS_N);

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         meas_cnt_r <= '0;
         meas_r     <= 1'b0;
      end
      else
      begin
         meas_r <= (meas_cnt_r >= period - TIM_W'(1));
         if (meas_cnt_r >= period - TIM_W'(1))
            meas_cnt_r <= '0;
         else
            meas_cnt_r <= meas_cnt_r + TIM_W'(1);
      end
   end

   // Time since the last interval result, saturating
   always_ff @(posedge core_clk)
   begin
      if (rst)
         since_r <= '0;
      else if (flow_vol_valid)
         since_r <= '0;
      else if (since_r != '1)
         since_r <= since_r + TIM_W'(1);
   end

   assign cur_mag = flow_vol[VOL_W-1] ? VOL_W'(-flow_vol) : flow_vol;
   // Counter reads one less than the cycles elapsed, hence the added one
   assign t_last  = (st_r == FMT_FIRST) ? (since_r - tb1_r) : (since_r + TIM_W'(1));

   // ==========================================================
   // Test sequencer and accumulator
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_r       <= FMT_DISARM;
         acc_r      <= '0;
         settle_r   <= '0;
         rdy_r      <= 1'b0;
         inhib_r    <= 1'b0;
         tb1_r      <= '0;
         last_mag_r <= '0;
         last_neg_r <= 1'b0;
         go_r       <= 1'b0;
         neg_r      <= 1'b0;
         num_r      <= '0;
         den_r      <= '0;
      end
      else
      begin
         go_r <= 1'b0;
         if (flow_vol_valid)
         begin
            last_mag_r <= cur_mag;
            last_neg_r <= flow_vol[VOL_W-1];
         end
         case (st_r)
            FMT_DISARM:
               if (verif_r && valid_r && gate_s_r)
                  st_r <= FMT_ARMED;
            FMT_ARMED, FMT_READY:
               if (!gate_s_r)
               begin
                  acc_r   <= '0;
                  rdy_r   <= 1'b0;
                  inhib_r <= 1'b0;
                  // Result in the start cycle counts wholly outside the test
                  tb1_r   <= flow_vol_valid ? '1 : since_r;
                  st_r    <= FMT_FIRST;
               end
            FMT_FIRST:
               if (flow_vol_valid)
               begin
                  // Share of V1 after the start
                  num_r <= NUM_W'(cur_mag * t_last);
                  den_r <= (since_r == '1) ? since_r : (since_r + TIM_W'(1));
                  neg_r <= flow_vol[VOL_W-1];
                  go_r  <= 1'b1;
                  st_r  <= FMT_DIVF;
               end
               else if (gate_s_r)
               begin
                  num_r   <= NUM_W'(last_mag_r * t_last);
                  den_r   <= period;
                  neg_r   <= last_neg_r;
                  go_r    <= 1'b1;
                  inhib_r <= 1'b1;
                  st_r    <= FMT_DIVL;
               end
            FMT_DIVF:
               if (dv_done)
               begin
                  acc_r <= neg_r ? acc_r - ACC_W'(dv_quo) : acc_r + ACC_W'(dv_quo);
                  st_r  <= FMT_RUN;
               end
            FMT_RUN:
               if (flow_vol_valid)
                  acc_r <= acc_r + ACC_W'(flow_vol);
               else if (gate_s_r)
               begin
                  // Elapsed share of Vn before the stop
                  num_r   <= NUM_W'(last_mag_r * t_last);
                  den_r   <= period;
                  neg_r   <= last_neg_r;
                  go_r    <= 1'b1;
                  inhib_r <= 1'b1;
                  st_r    <= FMT_DIVL;
               end
            FMT_DIVL:
               if (dv_done)
               begin
                  acc_r    <= neg_r ? acc_r - ACC_W'(dv_quo) : acc_r + ACC_W'(dv_quo);
                  settle_r <= '0;
                  st_r     <= FMT_SETTLE;
               end
            FMT_SETTLE:
               if (settle_r >= SETTLE_N - 32'h1)
               begin
                  rdy_r <= 1'b1;
                  st_r  <= FMT_READY;
               end
               else
                  settle_r <= settle_r + 32'h1;
            default:
               st_r <= FMT_DISARM;
         endcase
      end
   end

   fmt_serdiv
   #(
      .NUM_W (NUM_W),
      .DEN_W (TIM_W)
   )
   u_div
   (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (go_r),
      .num      (num_r),
      .den      (den_r),
      .busy     (),
      .done     (dv_done),
      .quo      (dv_quo)
   );

   // ==========================================================
   // Per-second pulse count
   // Results below cut-off or negative are dropped before summing
   assign sacc_in = (flow_vol_valid && flow_vol >= MIN_CUTOFF) ? 32'(flow_vol) : 32'sh0;

   always_comb
   begin
      if (sacc_r <= 32'sh0)
         cnt_nxt = 8'h00;
      else if ((sacc_r >>> FRAC_W) >= 32'(MAX_PULSES))
         cnt_nxt = MAX_PULSES;
      else
         cnt_nxt = 8'(sacc_r >>> FRAC_W);
   end

   assign pen = valid_r && !inhib_r;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sec_r  <= '0;
         sacc_r <= '0;
         pend_r <= '0;
      end
      else
      begin
         if (sec_r >= SEC_N - 32'h1)
         begin
            sec_r  <= '0;
            // Fraction carries over; whole pulses above MAX_PULSES, or counted while pen is low, are lost
            sacc_r <= 32'(sacc_r[FRAC_W-1:0]) + sacc_in;
            pend_r <= pen ? cnt_nxt : 8'h00;
         end
         else
         begin
            sec_r  <= sec_r + 32'h1;
            sacc_r <= sacc_r + sacc_in;
            if (!pen)
               pend_r <= 8'h00;
            else if (ph_r == FMT_PH_IDLE && pend_r != 8'h00)
               pend_r <= pend_r - 8'h01;
         end
      end
   end

   // ==========================================================
   // Pulse shaper
   // 16-pulse bursts at 200 Hz with 30 ms gaps fit 128 within a second
   always_ff @(posedge core_clk)
   begin
      if (rst || !pen)
      begin
         ph_r    <= FMT_PH_IDLE;
         ptmr_r  <= '0;
         burst_r <= '0;
         pulse_r <= 1'b0;
      end
      else
      begin
         case (ph_r)
            FMT_PH_IDLE:
               if (pend_r != 8'h00)
               begin
                  pulse_r <= 1'b1;
                  ptmr_r  <= PULSE_N - 32'h1;
                  ph_r    <= FMT_PH_HI;
               end
            FMT_PH_HI:
               if (ptmr_r == '0)
               begin
                  pulse_r <= 1'b0;
                  ptmr_r  <= PULSE_N - 32'h1;
                  ph_r    <= FMT_PH_LO;
               end
               else
                  ptmr_r <= ptmr_r - 32'h1;
            FMT_PH_LO:
               if (ptmr_r != '0)
                  ptmr_r <= ptmr_r - 32'h1;
               else if (burst_r == BURST_LAST)
               begin
                  burst_r <= '0;
                  ptmr_r  <= GAP_N - 32'h1;
                  ph_r    <= FMT_PH_GAP;
               end
               else
               begin
                  burst_r <= burst_r + 4'h1;
                  ph_r    <= FMT_PH_IDLE;
               end
            FMT_PH_GAP:
               if (ptmr_r == '0)
                  ph_r <= FMT_PH_IDLE;
               else
                  ptmr_r <= ptmr_r - 32'h1;
            default:
               ph_r <= FMT_PH_IDLE;
         endcase
         // Fresh burst each second, so every second shows one pattern
         if (sec_r >= SEC_N - 32'h1)
            burst_r <= '0;
      end
   end

   // ==========================================================
   // Outputs
   assign meas_start     = meas_r;
   assign verif_mode     = verif_r;
   assign out_valid      = valid_r;
   assign test_running   = (st_r == FMT_FIRST) || (st_r == FMT_DIVF) || (st_r == FMT_RUN);
   assign test_vol       = acc_r;
   assign test_vol_valid = rdy_r;
   assign pulse_out      = pulse_r;

endmodule : fmt_gated_accum
`default_nettype wire

//--- rtl/fmt_pkg.sv
// Purpose: Shared constants for the flow meter test-mode gated accumulator
// Assumes: 250 MHz core clock
// Notes:   Times kept in their own units, cycle counts derived from them
package fmt_pkg;

   // ==========================================================
   // Clock
   localparam longint unsigned CLK_KHZ       = 64'd250000;

   // ==========================================================
   // Times in their own units
   localparam longint unsigned ENTRY_MS      = 64'd1000;
   localparam longint unsigned SEC_MS        = 64'd1000;
   localparam longint unsigned SETTLE_MS     = 64'd2000;
   localparam longint unsigned STARTUP_MS    = 64'd16000;
   localparam longint unsigned PULSE_US      = 64'd2500;
   localparam longint unsigned GAP_MS        = 64'd30;
   localparam longint unsigned MEAS_MS       = 64'd1000;

   // ==========================================================
   // Derived cycle counts
   localparam longint unsigned ENTRY_CYC     = ENTRY_MS * CLK_KHZ;
   localparam longint unsigned SEC_CYC       = SEC_MS * CLK_KHZ;
   localparam longint unsigned SETTLE_CYC    = SETTLE_MS * CLK_KHZ;
   localparam longint unsigned STARTUP_CYC   = STARTUP_MS * CLK_KHZ;
   localparam longint unsigned PULSE_CYC     = (PULSE_US * CLK_KHZ) / 64'd1000;
   localparam longint unsigned GAP_CYC       = GAP_MS * CLK_KHZ;
   localparam longint unsigned MEAS_CYC      = MEAS_MS * CLK_KHZ;

   // ==========================================================
   // Behaviour constants
   localparam int unsigned     TEST_SPEEDUP  = 4;
   localparam logic [31:0]     STRAP_AT_CYC  = 32'h0000_0003;
   localparam logic [7:0]      MAX_PULSES    = 8'h80;
   localparam int unsigned     FRAC_W        = 8;
   localparam logic [3:0]      BURST_LAST    = 4'hf;
   localparam int unsigned     VOL_W         = 24;
   localparam int unsigned     TIM_W         = 28;
   localparam int unsigned     ACC_W         = 40;

   // ==========================================================
   // Test sequencer states, Gray along the usual path
   typedef enum logic [2:0]
   {
      FMT_DISARM = 3'h0,
      FMT_ARMED  = 3'h1,
      FMT_FIRST  = 3'h3,
      FMT_DIVF   = 3'h2,
      FMT_RUN    = 3'h6,
      FMT_DIVL   = 3'h7,
      FMT_SETTLE = 3'h5,
      FMT_READY  = 3'h4
   } fmt_state_e;

   // Pulse emitter phases
   typedef enum logic [1:0]
   {
      FMT_PH_IDLE = 2'h0,
      FMT_PH_HI   = 2'h1,
      FMT_PH_LO   = 2'h3,
      FMT_PH_GAP  = 2'h2
   } fmt_phase_e;

endpackage : fmt_pkg

//--- rtl/fmt_serdiv.sv
// Purpose: Serial restoring unsigned divider, one quotient bit per cycle
// Assumes: den nonzero; start ignored while busy
// Notes:   Takes NUM_W cycles; done is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module fmt_serdiv
   import fmt_pkg::*;
#(
   parameter int unsigned NUM_W = 52,
   parameter int unsigned DEN_W = 28
)
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Request
   input  wire logic             start,
   input  wire logic [NUM_W-1:0] num,
   input  wire logic [DEN_W-1:0] den,
   // Answer
   output logic                  busy,
   output logic                  done,
   output logic      [NUM_W-1:0] quo
);
   localparam int unsigned CNT_W = $clog2(NUM_W + 1);

   logic [DEN_W-1:0] rem_r;
   logic [NUM_W-1:0] quo_r;
   logic [DEN_W-1:0] den_r;
   logic [CNT_W-1:0] cnt_r;
   logic             busy_r;
   logic             done_r;
   logic [DEN_W:0]   trial;
   logic             ge;
   logic [DEN_W:0]   rem_nxt;

   // ==========================================================
   // One restoring step
   always_comb
   begin
      trial   = {rem_r, quo_r[NUM_W-1]};
      ge      = (trial >= {1'b0, den_r});
      rem_nxt = ge ? (trial - {1'b0, den_r}) : trial;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rem_r  <= '0;
         quo_r  <= '0;
         den_r  <= '0;
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (start && !busy_r)
         begin
            quo_r  <= num;
            den_r  <= den;
            rem_r  <= '0;
            cnt_r  <= CNT_W'(NUM_W);
            busy_r <= 1'b1;
         end
         else if (busy_r)
         begin
            rem_r <= rem_nxt[DEN_W-1:0];
            quo_r <= {quo_r[NUM_W-2:0], ge};
            cnt_r <= cnt_r - CNT_W'(1);
            if (cnt_r == CNT_W'(1))
            begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   assign busy = busy_r;
   assign done = done_r;
   assign quo  = quo_r;

endmodule : fmt_serdiv
`default_nettype wire

//--- verification/fmt_gated_accum_asserts.sv
// Purpose: Port-level checks for fmt_gated_accum
// Assumes: One clock, sync active-high reset
// Notes:   Counts handed over by the bind
`timescale 1ns/1ns
`default_nettype none
module fmt_gated_accum_asserts
   import fmt_pkg::*;
#(
   parameter int unsigned ENTRY_N   = 100,
   parameter int unsigned SETTLE_N  = 200,
   parameter int unsigned STARTUP_N = 300,
   parameter int unsigned PULSE_N   = 20,
   parameter int unsigned MEAS_N    = 400
)
(
   // Clock and reset
   input wire logic             core_clk,
   input wire logic             rst,
   // Observed outputs
   input wire logic             meas_start,
   input wire logic             verif_mode,
   input wire logic             out_valid,
   input wire logic             test_running,
   input wire logic [ACC_W-1:0] test_vol,
   input wire logic             test_vol_valid,
   input wire logic             pulse_out
);
   // =====================================
   // Helper counters
   localparam int ST_LO = SETTLE_N;
   localparam int ST_HI = SETTLE_N + 80;
   logic [31:0] cyc_r;
   logic [31:0] gap_r;
   logic [31:0] hi_r;
   logic [31:0] stop_r;
   logic        seen_r;
   logic        prev_v_r;
   always_ff @(posedge core_clk)
      cyc_r <= rst ? 32'h0 : cyc_r + 32'h1;
   always_ff @(posedge core_clk)
      gap_r <= meas_start ? 32'h1 : gap_r + 32'h1;
   always_ff @(posedge core_clk)
      hi_r <= pulse_out ? hi_r + 32'h1 : 32'h0;
   // Saturates so a long idle never wraps
   always_ff @(posedge core_clk)
      stop_r <= test_running ? 32'h0 : stop_r + {31'h0, ~&stop_r};
   always_ff @(posedge core_clk)
      seen_r <= rst ? 1'b0 : (seen_r | meas_start);
   always_ff @(posedge core_clk)
      prev_v_r <= meas_start ? verif_mode : prev_v_r;

   // =====================================
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_entry_time: assert property ($rose(verif_mode) |-> cyc_r >= ENTRY_N && cyc_r <= ENTRY_N + 3)
      else $error("verification mode entry time off");
   chk_mode_sticky: assert property (verif_mode |=> verif_mode)
      else $error("verification mode dropped");
   chk_meas_period: assert property (meas_start && seen_r && prev_v_r == verif_mode
      |-> gap_r == (verif_mode ? 32'(MEAS_N / TEST_SPEEDUP) : 32'(MEAS_N)))
      else $error("measuring period wrong");
   chk_startup_gap: assert property ($rose(out_valid) |-> cyc_r >= STARTUP_N && cyc_r <= STARTUP_N + 3)
      else $error("output valid time off");
   chk_quiet_boot: assert property (!out_valid |-> !pulse_out)
      else $error("pulse before output valid");
   chk_pulse_width: assert property (hi_r <= 32'(PULSE_N))
      else $error("pulse too long");
   chk_stop_quiet: assert property ($fell(test_running) |-> ##[0:2] (!pulse_out [*8]))
      else $error("pulses after stop");
   chk_test_mode: assert property (test_running |-> verif_mode && out_valid)
      else $error("test outside verification mode");
   chk_settle_min: assert property ($rose(test_vol_valid) |-> stop_r >= SETTLE_N)
      else $error("result presented too early");
   chk_settle_max: assert property ($fell(test_running) |-> ##[ST_LO:ST_HI] test_vol_valid)
      else $error("result not presented");
   chk_result_hold: assert property (test_vol_valid && $past(test_vol_valid) |-> $stable(test_vol))
      else $error("result changed while valid");
   chk_start_clear: assert property ($rose(test_running) |-> ##[0:1] !test_vol_valid)
      else $error("old result kept at start");
endmodule : fmt_gated_accum_asserts

bind fmt_gated_accum fmt_gated_accum_asserts #(
   .ENTRY_N(ENTRY_N), .SETTLE_N(SETTLE_N), .STARTUP_N(STARTUP_N), .PULSE_N(PULSE_N), .MEAS_N(MEAS_N)
) fmt_gated_accum_asserts_i (
   .core_clk(core_clk), .rst(rst), .meas_start(meas_start), .verif_mode(verif_mode),
   .out_valid(out_valid), .test_running(test_running), .test_vol(test_vol),
   .test_vol_valid(test_vol_valid), .pulse_out(pulse_out)
);
`default_nettype wire

//--- verification/fmt_engine_model.sv
// Purpose: Measuring engine answering each interval start
// Assumes: Interval longer than DLY
// Notes:   Data is garbage outside the valid cycle
`timescale 1ns/1ns
`default_nettype none
module fmt_engine_model
   import fmt_pkg::*;
#(
   parameter int unsigned DLY = 10
)
(
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // Device side
   input  wire logic                    meas_start,
   output logic                         flow_vol_valid,
   output logic signed [VOL_W-1:0]      flow_vol,
   // Flow chosen by the bench
   input  wire logic signed [VOL_W-1:0] flow_set
);
   logic [7:0] wait_r;
   always_ff @(posedge core_clk)
   begin
      if (rst)
         wait_r <= 8'h0;
      else if (meas_start)
         wait_r <= 8'(DLY);
      else if (wait_r != 8'h0)
         wait_r <= wait_r - 8'h1;
   end
   // One result per interval, feeding pulses and test sum alike
   always_ff @(posedge core_clk)
      flow_vol_valid <= !rst && wait_r == 8'h1;
   // Inverted when idle so a stale sample cannot pass as good
   always_ff @(posedge core_clk)
      flow_vol <= (wait_r == 8'h1) ? flow_set : ~flow_vol;
endmodule : fmt_engine_model
`default_nettype wire

//--- verification/fmt_gated_accum_tb.sv
// Purpose: Self-checking bench for fmt_gated_accum
// Assumes: Shortened counts, verification period 100 cycles
// Notes:   Bench plays the rig on the gate line
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
   begin \
      checks_done++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); \
      end \
   end
module fmt_gated_accum_tb
   import fmt_pkg::*;
;
   // Shortened counts; pulse timing still fits 128 pulses in a second
   localparam int unsigned ENTRY_N   = 100;
   localparam int unsigned SEC_N     = 2000;
   localparam int unsigned SETTLE_N  = 200;
   localparam int unsigned STARTUP_N = 300;
   localparam int unsigned PULSE_N   = 4;
   localparam int unsigned GAP_N     = 50;
   localparam int unsigned MEAS_N    = 400;
   typedef struct {logic signed [VOL_W-1:0] vol; int n;} fmt_row_s;
   // =====================================
   // Rows: flow per result, pulses over three seconds
   fmt_row_s rows [4] = '{
      '{24'hfffe00, 0},
      '{24'h000000, 0},
      '{24'h000500, 300},
      '{24'h001000, 384}
   };
   logic                    core_clk;
   logic                    rst;
   logic                    gate_pin_n;
   logic                    meas_start;
   logic                    flow_vol_valid;
   logic signed [VOL_W-1:0] flow_vol;
   logic signed [VOL_W-1:0] flow_set;
   logic                    verif_mode;
   logic                    out_valid;
   logic                    test_running;
   logic [ACC_W-1:0]        test_vol;
   logic                    test_vol_valid;
   logic                    pulse_out;
   logic                    p_prev;
   int                      rises;
   int                      r0;
   int                      err_count;
   int                      checks_done;
   int                      to_cnt;

   fmt_gated_accum #(
      .ENTRY_N(ENTRY_N), .SEC_N(SEC_N), .SETTLE_N(SETTLE_N), .STARTUP_N(STARTUP_N),
      .PULSE_N(PULSE_N), .GAP_N(GAP_N), .MEAS_N(MEAS_N)
   ) fmt_gated_accum_i (
      .core_clk(core_clk), .rst(rst), .gate_pin_n(gate_pin_n), .meas_start(meas_start),
      .flow_vol_valid(flow_vol_valid), .flow_vol(flow_vol), .verif_mode(verif_mode),
      .out_valid(out_valid), .test_running(test_running), .test_vol(test_vol),
      .test_vol_valid(test_vol_valid), .pulse_out(pulse_out)
   );
   fmt_engine_model fmt_engine_model_i (
      .core_clk(core_clk), .rst(rst), .meas_start(meas_start),
      .flow_vol_valid(flow_vol_valid), .flow_vol(flow_vol), .flow_set(flow_set)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      p_prev <= pulse_out;
      if (pulse_out === 1'b1 && p_prev === 1'b0)
         rises <= rises + 1;
      to_cnt <= to_cnt + 1;
      if (to_cnt == 60000)
      begin
         err_count++;
         final_report;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   // Gated test; no look at the result while it runs
   task automatic run_test(input logic signed [VOL_W-1:0] v, input int t);
      longint exp_v;
      longint got;
      flow_set <= v;
      tick(300);
      gate_pin_n <= 1'b0;
      tick(t / 2);
      `CHK(test_running, 1'b1)
      tick(t - t / 2);
      gate_pin_n <= 1'b1;
      // Sync delay and a pulse cut short at the stop must settle first
      tick(8);
      r0 = rises;
      tick(142);
      `CHK(test_vol_valid, 1'b0)
      `CHK(rises - r0, 0)
      tick(200);
      `CHK(test_vol_valid, 1'b1)
      exp_v = longint'(v) * t / longint'(MEAS_N / TEST_SPEEDUP);
      got = longint'($signed(test_vol));
      `CHK(got >= exp_v - 1024 && got <= exp_v + 1024, 1'b1)
   endtask : run_test

   task final_report;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   initial
   begin
      rst = 1'b1;
      gate_pin_n = 1'b0;
      flow_set = 24'h000000;
      rises = 0;
      p_prev = 1'b0;
      err_count = 0;
      checks_done = 0;
      to_cnt = 0;
      tick(16);
      rst <= 1'b0;
      tick(120);
      `CHK(verif_mode, 1'b1)
      `CHK(out_valid, 1'b0)
      gate_pin_n <= 1'b1;
      tick(200);
      `CHK(verif_mode, 1'b1)
      `CHK(out_valid, 1'b1)
      foreach (rows[i])
      begin
         flow_set <= rows[i].vol;
         tick(2 * SEC_N);
         r0 = rises;
         tick(3 * SEC_N);
         `CHK(rises - r0, rows[i].n)
      end
      // Tests far shorter than a real calibration run
      run_test(24'h006400, 1050);
      run_test(24'h003200, 500);
      // Second power-up without the strap stays in normal mode
      rst <= 1'b1;
      tick(16);
      rst <= 1'b0;
      tick(400);
      `CHK(verif_mode, 1'b0)
      gate_pin_n <= 1'b0;
      tick(900);
      `CHK(test_running, 1'b0)
      final_report;
   end
endmodule : fmt_gated_accum_tb
`undef CHK
`default_nettype wire
